/* adc_config_consts.svh */
// Register offsets, reset values and field positions of the converter configuration bank
`ifndef ADC_CONFIG_CONSTS_SVH
`define ADC_CONFIG_CONSTS_SVH
`define ADDR_PORT_CFG 13'h0000
`define ADDR_CHIP_ID 13'h0001
`define ADDR_CHIP_GRADE 13'h0002
`define ADDR_SHADOW_LO 13'h0008
`define ADDR_POWER_MODES 13'h0008
`define ADDR_GLOBAL_CLOCK 13'h0009
`define ADDR_OUTPUT_MODE 13'h0014
`define ADDR_VREF_SEL 13'h0018
`define ADDR_FUNC_HI 13'h0030
`define ADDR_COMMIT 13'h00ff
`define ADDR_DIGITAL 13'h0100
`define RST_PORT_CFG 8'h18
`define RST_VREF_SEL 8'hc0
`define RST_SHADOW 8'h00
`define RST_POWER_MODES 8'h80
`define RST_GLOBAL_CLOCK 8'h01
`define RST_DIGITAL 8'h00
`define COMMIT_VALUE 8'h01
`define BIT_LSB_HI 6
`define BIT_LSB_LO 1
`define BIT_SRST_HI 5
`define BIT_SRST_LO 2
`define SHADOW_COUNT 17
`define INSTR_BITS 16
`define WORD_BITS 8
`endif

/* adc_config_pkg.sv */
// Types shared by the converter configuration bank
package adc_config_pkg;
	typedef enum logic [1:0] {
		st_instr,
		st_data
	} frame_state_e;
	typedef logic [7:0] byte_t;
	typedef logic [12:0] addr_t;
endpackage

/* adc_config_register_bank.sv */
// Strap decoding, serial port and shadowed register space of the converter
`timescale 1ns/1ps
`include "adc_config_consts.svh"

// What this block does
// - Strap mode: stabilizer follows data strap, format strap picks two's complement.
// - Output-disable pin high tristates data outputs, low drives them.
// - Power-down pin high enters low power; register picks power-down or standby.
// - Output-style pin picks CMOS or LVDS; swing pin picks reduced LVDS levels.
// - Decode sections 0x00-0x02, 0xFF, 0x08-0x30 and 0x100.
// - Reference select at 0x18 resets to 0xC0.
// - Reset loads every register with its default before serial access.
// - Addresses 0x08-0x18 are shadowed; writes act only after transfer.
// - Writing 0x01 to 0xFF copies all shadows to active at once.
// - Transfer bit clears itself after the update, reads zero.
// - Frame is 16-bit instruction, read/write first, then bytes; read turns line.
// - Data bytes shift MSB first until LSB-first is selected; the instruction always shifts MSB first.
// - Chip select high at power-up means straps; once low, stays serial.
module adc_config_register_bank (
	input wire logic clock,
	input wire logic reset,
	input wire logic clock_enable,
	input wire logic chip_select_n,
	input wire logic serial_clock_format_strap,
	input wire logic serial_data_stabilizer_strap_in,
	output logic serial_data_stabilizer_strap_out,
	output logic serial_data_stabilizer_strap_oe,
	input wire logic output_disable_pin,
	input wire logic power_down_pin,
	input wire logic output_style_pin,
	input wire logic reduced_swing_select_pin,
	output logic duty_cycle_stabilizer,
	output logic twos_complement,
	output logic data_output_enable,
	output logic full_power_down,
	output logic standby,
	output logic lvds_mode,
	output logic lvds_reduced_swing,
	output logic serial_mode,
	output logic [7:0] vref_select,
	output logic [7:0] digital_control
);
	// Arbitrary neutral identity values
	localparam logic [7:0] CHIP_ID = 8'h5a;
	localparam logic [7:0] CHIP_GRADE = 8'h00;

	function automatic logic is_shadow(input adc_config_pkg::addr_t a);
		is_shadow = (a >= `ADDR_SHADOW_LO) && (a <= `ADDR_VREF_SEL);
	endfunction

	function automatic logic is_mapped(input adc_config_pkg::addr_t a);
		is_mapped = (a <= `ADDR_CHIP_GRADE) || (a == `ADDR_COMMIT) ||
			((a >= `ADDR_SHADOW_LO) && (a <= `ADDR_FUNC_HI)) ||
			(a == `ADDR_DIGITAL);
	endfunction

	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic [5:0] pin1_reg;
	logic [5:0] pin2_reg;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sclk_d_reg;
	logic sclk_rise;
	logic sclk_fall;

	// Pin synchronisers; first stage read only by second
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			sync1_reg <= 5'h01;
			sync2_reg <= 5'h01;
			pin1_reg <= 6'h00;
			pin2_reg <= 6'h00;
		end else if (clock_enable) begin
			sync1_reg <= {serial_data_stabilizer_strap_in,
				serial_clock_format_strap, 2'b00, chip_select_n};
			sync2_reg <= sync1_reg;
			pin1_reg <= {2'b00, output_disable_pin, power_down_pin,
				output_style_pin, reduced_swing_select_pin};
			pin2_reg <= pin1_reg;
		end
	end
	assign cs_n = sync2_reg[0];
	assign sclk = sync2_reg[3];
	assign sdi = sync2_reg[4];
	assign sclk_rise = sclk && !sclk_d_reg;
	assign sclk_fall = !sclk && sclk_d_reg;

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			sclk_d_reg <= 1'b0;
		else if (clock_enable)
			sclk_d_reg <= sclk;
	end

	// Serial mode latches once chip select is seen low
	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			serial_mode <= 1'b0;
		else if (clock_enable && !cs_n)
			serial_mode <= 1'b1;
	end

	adc_config_pkg::byte_t port_cfg_reg;
	adc_config_pkg::byte_t shadow_reg [0:`SHADOW_COUNT-1];
	adc_config_pkg::byte_t active_reg [0:`SHADOW_COUNT-1];
	adc_config_pkg::byte_t func_reg [0:`SHADOW_COUNT+23];
	adc_config_pkg::byte_t digital_reg;
	logic commit_reg;
	logic lsb_first;
	assign lsb_first = port_cfg_reg[`BIT_LSB_HI] | port_cfg_reg[`BIT_LSB_LO];

	// Frame engine
	adc_config_pkg::frame_state_e state_reg;
	logic [15:0] instr_reg;
	logic [4:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic [7:0] rd_shift_reg;
	logic is_read;
	logic wr_strobe;
	adc_config_pkg::addr_t addr_reg;
	adc_config_pkg::byte_t wr_byte;
	adc_config_pkg::byte_t rd_byte;
	logic [7:0] sh_next;

	assign is_read = instr_reg[15];
	assign sh_next = lsb_first ? {sdi, shift_reg[7:1]} :
		{shift_reg[6:0], sdi};
	assign wr_strobe = (state_reg == adc_config_pkg::st_data) && sclk_rise &&
		(bit_cnt_reg == 5'd7) && !is_read && !cs_n;
	assign wr_byte = sh_next;

	always_comb begin
		rd_byte = 8'h00;
		if (addr_reg == `ADDR_PORT_CFG)
			rd_byte = port_cfg_reg;
		else if (addr_reg == `ADDR_CHIP_ID)
			rd_byte = CHIP_ID;
		else if (addr_reg == `ADDR_CHIP_GRADE)
			rd_byte = CHIP_GRADE;
		else if (addr_reg == `ADDR_COMMIT)
			rd_byte = {7'h00, commit_reg};
		else if (addr_reg == `ADDR_DIGITAL)
			rd_byte = digital_reg;
		else if (is_shadow(addr_reg))
			rd_byte = shadow_reg[5'(addr_reg - `ADDR_SHADOW_LO)];
		else if (is_mapped(addr_reg))
			rd_byte = func_reg[6'(addr_reg - `ADDR_SHADOW_LO)];
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg <= adc_config_pkg::st_instr;
			instr_reg <= 16'h0000;
			bit_cnt_reg <= 5'h00;
			shift_reg <= 8'h00;
			addr_reg <= 13'h0000;
		end else if (clock_enable) begin
			if (cs_n) begin
				state_reg <= adc_config_pkg::st_instr;
				bit_cnt_reg <= 5'h00;
			end else if (sclk_rise) begin
				case (state_reg)
					adc_config_pkg::st_instr: begin
						instr_reg <= {instr_reg[14:0], sdi};
						if (bit_cnt_reg == 5'(`INSTR_BITS - 1)) begin
							addr_reg <= {instr_reg[11:0], sdi};
							bit_cnt_reg <= 5'h00;
							state_reg <= adc_config_pkg::st_data;
						end else
							bit_cnt_reg <= bit_cnt_reg + 5'd1;
					end
					adc_config_pkg::st_data: begin
						shift_reg <= sh_next;
						if (bit_cnt_reg == 5'(`WORD_BITS - 1)) begin
							bit_cnt_reg <= 5'h00;
							// Streaming steps the address
							addr_reg <= lsb_first ? addr_reg + 13'd1 :
								addr_reg - 13'd1;
						end else
							bit_cnt_reg <= bit_cnt_reg + 5'd1;
					end
					default: state_reg <= adc_config_pkg::st_instr;
				endcase
			end
		end
	end

	// Read data is launched on falling serial clock edges
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rd_shift_reg <= 8'h00;
			serial_data_stabilizer_strap_out <= 1'b0;
			serial_data_stabilizer_strap_oe <= 1'b0;
		end else if (clock_enable) begin
			if (cs_n || state_reg != adc_config_pkg::st_data || !is_read) begin
				serial_data_stabilizer_strap_oe <= 1'b0;
			end else if (sclk_fall) begin
				serial_data_stabilizer_strap_oe <= 1'b1;
				if (bit_cnt_reg == 5'h00) begin
					serial_data_stabilizer_strap_out <= lsb_first ?
						rd_byte[0] : rd_byte[7];
					rd_shift_reg <= lsb_first ? {1'b0, rd_byte[7:1]} :
						{rd_byte[6:0], 1'b0};
				end else begin
					serial_data_stabilizer_strap_out <= lsb_first ?
						rd_shift_reg[0] : rd_shift_reg[7];
					rd_shift_reg <= lsb_first ? {1'b0, rd_shift_reg[7:1]} :
						{rd_shift_reg[6:0], 1'b0};
				end
			end
		end
	end

	// Register writes; soft reset and reset restore defaults
	logic soft_reset;
	assign soft_reset = wr_strobe && (addr_reg == `ADDR_PORT_CFG) &&
		(wr_byte[`BIT_SRST_HI] | wr_byte[`BIT_SRST_LO]);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			port_cfg_reg <= `RST_PORT_CFG;
			digital_reg <= `RST_DIGITAL;
			commit_reg <= 1'b0;
		end else if (clock_enable) begin
			commit_reg <= 1'b0;
			if (soft_reset) begin
				port_cfg_reg <= `RST_PORT_CFG;
				digital_reg <= `RST_DIGITAL;
			end else if (wr_strobe) begin
				if (addr_reg == `ADDR_PORT_CFG)
					port_cfg_reg <= {1'b0, wr_byte[`BIT_LSB_HI] | wr_byte[`BIT_LSB_LO],
						2'b01, 2'b10, wr_byte[`BIT_LSB_HI] | wr_byte[`BIT_LSB_LO],
						1'b0} | `RST_PORT_CFG;
				else if (addr_reg == `ADDR_DIGITAL)
					digital_reg <= wr_byte;
				else if (addr_reg == `ADDR_COMMIT)
					commit_reg <= wr_byte == `COMMIT_VALUE;
			end
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `SHADOW_COUNT + 24; gi = gi + 1) begin : g_func
			localparam adc_config_pkg::addr_t A = 13'(`ADDR_SHADOW_LO + gi);
			localparam logic [7:0] RV = (A == `ADDR_VREF_SEL) ? `RST_VREF_SEL :
				(A == `ADDR_POWER_MODES) ? `RST_POWER_MODES :
				(A == `ADDR_GLOBAL_CLOCK) ? `RST_GLOBAL_CLOCK :
				`RST_SHADOW;
			always_ff @(posedge clock or posedge reset) begin
				if (reset)
					func_reg[gi] <= RV;
				else if (clock_enable) begin
					if (soft_reset)
						func_reg[gi] <= RV;
					else if (wr_strobe && addr_reg == A)
						func_reg[gi] <= wr_byte;
				end
			end
			if (gi < `SHADOW_COUNT) begin : g_sh
				assign shadow_reg[gi] = func_reg[gi];
				always_ff @(posedge clock or posedge reset) begin
					if (reset)
						active_reg[gi] <= RV;
					else if (clock_enable) begin
						if (soft_reset)
							active_reg[gi] <= RV;
						else if (commit_reg)
							active_reg[gi] <= func_reg[gi];
					end
				end
			end
		end
	endgenerate

	// Operating outputs from pins and active registers
	logic [1:0] pd_mode;
	logic pd_is_standby;
	assign pd_mode = active_reg[0][1:0];
	assign pd_is_standby = active_reg[0][5];

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			duty_cycle_stabilizer <= 1'b1;
			twos_complement <= 1'b0;
			data_output_enable <= 1'b0;
			full_power_down <= 1'b0;
			standby <= 1'b0;
			lvds_mode <= 1'b0;
			lvds_reduced_swing <= 1'b0;
			vref_select <= `RST_VREF_SEL;
			digital_control <= `RST_DIGITAL;
		end else if (clock_enable) begin
			if (!serial_mode) begin
				duty_cycle_stabilizer <= sdi;
				twos_complement <= sclk;
			end else begin
				duty_cycle_stabilizer <= active_reg[1][0] |
					(active_reg[3][2:0] != 3'h0);
				twos_complement <= active_reg[12][0];
			end
			data_output_enable <= !pin2_reg[3];
			full_power_down <= (pin2_reg[2] && !pd_is_standby) ||
				(pd_mode == 2'b01);
			standby <= (pin2_reg[2] && pd_is_standby) ||
				(pd_mode == 2'b10);
			lvds_mode <= pin2_reg[1];
			lvds_reduced_swing <= pin2_reg[1] && pin2_reg[0];
			vref_select <= active_reg[16];
			digital_control <= digital_reg;
		end
	end
endmodule

/* spi_host_model.sv */
// Serial port host model that frames reads and writes to the converter
`timescale 1ns/1ps
module spi_host_model (
	input wire logic clock,
	input wire logic data_in,
	output logic cs_n,
	output logic sclk,
	output logic data_out,
	output logic data_oe
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		data_out = 1'b1;
		data_oe = 1'b1;
	end
	// Straps share the serial pins, so the host drives them before any frame
	task automatic straps(input logic stab, input logic fmt);
		data_out = stab;
		sclk = fmt;
	endtask
	// Four clocks a half period gives the 200 ns link clock
	task automatic shift(input logic b, output logic r);
		data_out = b;
		repeat (4) @(posedge clock);
		#1 sclk = 1'b1;
		repeat (4) @(posedge clock);
		r = data_in;
		#1 sclk = 1'b0;
	endtask
	task automatic xfer(input logic rd, input adc_config_pkg::addr_t a,
		input adc_config_pkg::byte_t wd, output adc_config_pkg::byte_t rq);
		logic [23:0] w;
		logic r;
		w = {rd, 2'h0, a, wd};
		rq = 8'h00;
		@(posedge clock);
		#1 sclk = 1'b0;
		cs_n = 1'b0;
		for (int i = 23; i >= 0; i--) begin
			data_oe = !(rd && i < 8);
			shift(w[i], r);
			if (i < 8) begin
				rq[i] = r;
			end
		end
		// Hold select low so the last word lands before the frame closes
		repeat (8) @(posedge clock);
		#1 cs_n = 1'b1;
		data_oe = 1'b1;
		repeat (8) @(posedge clock);
	endtask
endmodule

/* adc_config_asserts.sv */
// Concurrent checks on the ports of the configuration bank
`timescale 1ns/1ps
module adc_config_asserts (
	input wire logic clock,
	input wire logic reset,
	input wire logic chip_select_n,
	input wire logic serial_clock_format_strap,
	input wire logic serial_data_stabilizer_strap_in,
	input wire logic serial_data_stabilizer_strap_oe,
	input wire logic output_disable_pin,
	input wire logic power_down_pin,
	input wire logic output_style_pin,
	input wire logic reduced_swing_select_pin,
	input wire logic duty_cycle_stabilizer,
	input wire logic twos_complement,
	input wire logic data_output_enable,
	input wire logic full_power_down,
	input wire logic standby,
	input wire logic lvds_mode,
	input wire logic lvds_reduced_swing,
	input wire logic serial_mode,
	input wire logic [7:0] vref_select
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	sequence cs_idle;
		chip_select_n [*6];
	endsequence
	sequence strap_mode(s);
		(!serial_mode && $stable(s)) [*6];
	endsequence
	a_stab_strap: assert property (strap_mode(serial_data_stabilizer_strap_in)
		|-> duty_cycle_stabilizer == serial_data_stabilizer_strap_in)
		else $error("stabilizer does not follow strap");
	a_format_strap: assert property (strap_mode(serial_clock_format_strap)
		|-> twos_complement == serial_clock_format_strap)
		else $error("format does not follow strap");
	a_oe_pin: assert property ($stable(output_disable_pin) [*6]
		|-> data_output_enable == !output_disable_pin)
		else $error("output enable does not follow pin");
	a_pd_pin: assert property (power_down_pin [*6]
		|-> full_power_down || standby) else $error("no low power state");
	a_style_pin: assert property ($stable(output_style_pin) [*6]
		|-> lvds_mode == output_style_pin) else $error("output style wrong");
	a_swing_pin: assert property
		((output_style_pin && reduced_swing_select_pin) [*6]
		|-> lvds_reduced_swing) else $error("reduced swing not set");
	a_serial_sticky: assert property (serial_mode |=> serial_mode)
		else $error("serial mode dropped");
	a_cs_serial: assert property (!chip_select_n [*6] |-> serial_mode)
		else $error("serial mode not entered");
	a_oe_idle: assert property (cs_idle |-> !serial_data_stabilizer_strap_oe)
		else $error("data pin driven while deselected");
	a_active_hold: assert property (cs_idle |=> $stable(vref_select))
		else $error("active reference changed outside a frame");
endmodule
bind adc_config_register_bank adc_config_asserts chk (.*);

/* tb.sv */
// Self-checking bench of the converter configuration bank
`timescale 1ns/1ps
`include "adc_config_consts.svh"
module tb;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic out_dis = 1'b0, pdn = 1'b0, sty = 1'b0, rs = 1'b0;
	logic cs_n, sck, h_out, h_oe, d_out, d_oe, data_pin;
	logic stab, twos, doe, fpd, stb, lvds, rsw, smode;
	adc_config_pkg::byte_t vref, dig, rd;
	int bad_count = 0;
	int num_checks = 0;
	int cyc = 0;
	// Strap inputs {stab, fmt, disable, pdn, style, swing} beside outputs
	logic [11:0] rows [5] = '{12'h828, 12'h418, 12'h304, 12'hcfb, 12'h8aa};
	spi_host_model host (.clock(clock), .data_in(data_pin), .cs_n(cs_n),
		.sclk(sck), .data_out(h_out), .data_oe(h_oe));
	// A released line shows the inverse of the last value, never a hold
	assign data_pin = d_oe ? d_out : (h_oe ? h_out : !h_out);
	adc_config_register_bank uut (.clock(clock), .reset(reset),
		.clock_enable(1'b1), .chip_select_n(cs_n),
		.serial_clock_format_strap(sck),
		.serial_data_stabilizer_strap_in(data_pin),
		.serial_data_stabilizer_strap_out(d_out),
		.serial_data_stabilizer_strap_oe(d_oe), .output_disable_pin(out_dis),
		.power_down_pin(pdn), .output_style_pin(sty),
		.reduced_swing_select_pin(rs), .duty_cycle_stabilizer(stab),
		.twos_complement(twos), .data_output_enable(doe),
		.full_power_down(fpd), .standby(stb), .lvds_mode(lvds),
		.lvds_reduced_swing(rsw), .serial_mode(smode),
		.vref_select(vref), .digital_control(dig));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk1(input logic g, input logic e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: bit %b want %b", $time, g, e);
		end
	endtask
	task automatic chk8(input adc_config_pkg::byte_t g,
		input adc_config_pkg::byte_t e);
		num_checks++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: byte %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input adc_config_pkg::addr_t a,
		input adc_config_pkg::byte_t d);
		host.xfer(1'b0, a, d, rd);
	endtask
	task automatic rdc(input adc_config_pkg::addr_t a,
		input adc_config_pkg::byte_t e);
		host.xfer(1'b1, a, 8'h00, rd);
		chk8(rd, e);
	endtask
	initial forever #12.5 clock = !clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		#1 reset = 1'b0;
		chk8(vref, `RST_VREF_SEL);
		chk8(dig, `RST_DIGITAL);
		chk1(smode, 1'b0);
		chk1(d_oe, 1'b0);
		$display("test reset done");
		foreach (rows[k]) begin
			host.straps(rows[k][11], rows[k][10]);
			{out_dis, pdn, sty, rs} = rows[k][9:6];
			repeat (8) @(posedge clock);
			#1;
			chk1(stab, rows[k][5]);
			chk1(twos, rows[k][4]);
			chk1(doe, rows[k][3]);
			chk1(fpd, rows[k][2]);
			chk1(stb, 1'b0);
			chk1(lvds, rows[k][1]);
			chk1(rsw, rows[k][0]);
		end
		$display("test straps done");
		{out_dis, pdn, sty, rs} = 4'h0;
		rdc(`ADDR_PORT_CFG, `RST_PORT_CFG);
		chk1(smode, 1'b1);
		chk1(stab, 1'b1);
		rdc(`ADDR_VREF_SEL, `RST_VREF_SEL);
		// Fully open location is only read, never written
		rdc(13'h0013, 8'h00);
		wr(`ADDR_VREF_SEL, 8'h40);
		chk8(vref, `RST_VREF_SEL);
		wr(`ADDR_COMMIT, `COMMIT_VALUE);
		chk8(vref, 8'h40);
		rdc(`ADDR_COMMIT, 8'h00);
		wr(`ADDR_POWER_MODES, 8'ha0);
		wr(`ADDR_OUTPUT_MODE, 8'h01);
		chk1(twos, 1'b0);
		wr(`ADDR_COMMIT, `COMMIT_VALUE);
		chk1(twos, 1'b1);
		#1 pdn = 1'b1;
		repeat (8) @(posedge clock);
		#1;
		chk1(stb, 1'b1);
		chk1(fpd, 1'b0);
		pdn = 1'b0;
		wr(`ADDR_DIGITAL, 8'h5a);
		chk8(dig, 8'h5a);
		wr(`ADDR_PORT_CFG, 8'h42);
		// An MSB-first host sees LSB-first bytes bit-reversed
		rdc(`ADDR_PORT_CFG, 8'h5a);
		rdc(`ADDR_VREF_SEL, 8'h02);
		// The soft reset byte reads the same in either bit order
		wr(`ADDR_PORT_CFG, 8'h24);
		chk8(vref, `RST_VREF_SEL);
		chk8(dig, `RST_DIGITAL);
		rdc(`ADDR_PORT_CFG, `RST_PORT_CFG);
		chk1(smode, 1'b1);
		$display("test serial done");
		wrap_up();
	end
endmodule
